// ---- rtl/svt_pkg.sv ----
package svt_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TICK_W = 20;
  localparam int SEEK_STROBE_NS = 1000;
  localparam int SEEK_STROBE_CYC = (SEEK_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int STRB_W = 8;

  // Panel encodings
  localparam logic [3:0] FUNC_RANDOM = 4'h3;
  localparam logic [3:0] FUNC_MANUAL = 4'h8;
  localparam logic [3:0] TAG_SEEK = 4'h8;
  localparam logic [3:0] TAG_WRITE = 4'h1;
  localparam logic [3:0] TAG_IDLE = 4'h0;
  localparam logic [8:0] CYL_HOME = 9'h000;
  localparam logic [8:0] CYL_MAX = 9'h19A;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;

  // Register map, byte addresses
  localparam logic [3:0] REG_DELAY = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [9:0] DELAY_RST = 10'h064;
  localparam logic [9:0] DELAY_MAX = 10'h3E7;
  localparam int ST_TARGET_LSB = 0;
  localparam int ST_STATE_LSB = 9;
  localparam int ST_RUN_BIT = 12;
  localparam int ST_STOP_BIT = 13;

  typedef struct packed {
    logic [3:0] func;
    logic start;
    logic stop;
    logic [3:0] tag;
    logic [15:0] ctl;
  } svt_panel_t;

  typedef struct packed {
    logic [3:0] tag;
    logic [15:0] ctl;
    logic strobe;
  } svt_drive_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STRB = 3'b001,
    ST_WAIT = 3'b011,
    ST_PICK = 3'b010,
    ST_PARK = 3'b110
  } svt_state_t;
endpackage

// ---- rtl/svt_seek_manual.sv ----
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// Function
// - With the function selector at the random seek position, start runs the automatic random seek exercise.
// - A random run first seeks to cylinder 0, then to cylinders drawn from the pseudo-random sequence.
// - Stop during a random run ends it with one seek to cylinder 0 and no further seeks.
// - The interval between seeks is operator-set and shown as three decimal digits of milliseconds.
// - In manual mode, start raises the strobe to the drive with the tag set on the tag switches.
// - The manual strobe stays high exactly while start is held and drops on release.
// - In manual mode the four upper switches set the four-bit tag command.
// - The write tag code is never placed on the tag bus in any function.
// - Four indicators always follow the tag bits chosen on the upper switches.
// - Sixteen lower switches set the sixteen control bits.
// - The control word is presented while start is held so the drive takes it with the strobe.
// - Every seek uses tag 1000 with the cylinder on control bits 0 to 8.
// - No random-run seek target above cylinder 410 is issued; manual tag 1000 strobes carry the switch cylinder unchecked.
module svt_seek_manual
  import svt_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Front panel pins
  input wire svt_panel_t panel_pins,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Drive tag and control buses
  output svt_drive_t drive,
  // Indicators
  output logic [3:0] tag_led,
  output logic [11:0] delay_readout
);

  if (TICK_CYC < 1 || TICK_CYC >= (1 << TICK_W))
  begin : g_chk
    $error("TICK_CYC out of range");
  end

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
  localparam logic [STRB_W-1:0] STRB_LAST = STRB_W'(SEEK_STROBE_CYC - 1);

  typedef struct packed {
    svt_panel_t s1;
    svt_panel_t s2;
    svt_panel_t s3;
    svt_panel_t panel;
    logic start_prev;
    svt_state_t st;
    logic stopping;
    logic [8:0] lfsr;
    logic [8:0] target;
    logic [STRB_W-1:0] strb_cnt;
    logic [TICK_W-1:0] tick_cnt;
    logic [9:0] delay_reg;
    logic [9:0] delay_cnt;
    svt_drive_t drive;
    logic [3:0] tag_led;
    logic [11:0] readout;
    logic wait_rq;
    logic [31:0] rdata;
  } svt_regs_t;

  localparam svt_regs_t RESET_Q = '{lfsr: LFSR_SEED, delay_reg: DELAY_RST, wait_rq: 1'b1, st: ST_IDLE, default: '0};

  // x^9 + x^5 + 1, maximal length, never reaches zero from a nonzero seed
  function automatic logic [8:0] lfsr_next(input logic [8:0] v);
    lfsr_next = {v[7:0], v[8] ^ v[4]};
  endfunction

  function automatic logic [11:0] to_bcd(input logic [9:0] v);
    logic [21:0] sh;
    sh = {12'h000, v};
    for (int i = 0; i < 10; i++)
    begin
      for (int d = 0; d < 3; d++)
      begin
        if (sh[10+4*d +: 4] > 4'h4)
          sh[10+4*d +: 4] = sh[10+4*d +: 4] + 4'h3;
      end
      sh = {sh[20:0], 1'b0};
    end
    to_bcd = sh[21:10];
  endfunction

  svt_regs_t q_ff;
  svt_regs_t nxt_q;

  logic running;
  logic start_edge;
  logic tick;
  logic bus_req;
  logic [9:0] wr_delay;

  assign running = (q_ff.st != ST_IDLE);
  assign start_edge = q_ff.panel.start && !q_ff.start_prev;
  assign tick = (q_ff.tick_cnt == TICK_LAST);
  assign bus_req = avs_read || avs_write;

  always_comb
  begin
    nxt_q = q_ff;
    wr_delay = q_ff.delay_reg;

    // Three-stage pin sync; a change is taken once stages two and three agree
    nxt_q.s1 = panel_pins;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    if (q_ff.s2 == q_ff.s3)
      nxt_q.panel = q_ff.s3;
    nxt_q.start_prev = q_ff.panel.start;

    // Millisecond tick, restarted on entering a wait so the first tick is a full period
    nxt_q.tick_cnt = tick ? '0 : q_ff.tick_cnt + 1'b1;

    unique case (q_ff.st)
      ST_IDLE:
      begin
        if (q_ff.panel.func == FUNC_RANDOM && start_edge)
        begin
          nxt_q.target = CYL_HOME;
          nxt_q.stopping = 1'b0;
          nxt_q.strb_cnt = '0;
          nxt_q.st = ST_STRB;
        end
      end
      ST_STRB:
      begin
        nxt_q.strb_cnt = q_ff.strb_cnt + 1'b1;
        if (q_ff.strb_cnt == STRB_LAST)
        begin
          if (q_ff.stopping)
            nxt_q.st = ST_IDLE;
          else
          begin
            nxt_q.delay_cnt = q_ff.delay_reg;
            nxt_q.tick_cnt = '0;
            nxt_q.st = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        if (q_ff.delay_cnt == 10'h000)
          nxt_q.st = ST_PICK;
        else if (tick)
          nxt_q.delay_cnt = q_ff.delay_cnt - 1'b1;
      end
      ST_PICK:
      begin
        nxt_q.lfsr = lfsr_next(q_ff.lfsr);
        if (q_ff.lfsr <= CYL_MAX)
        begin
          nxt_q.target = q_ff.lfsr;
          nxt_q.strb_cnt = '0;
          nxt_q.st = ST_STRB;
        end
      end
      ST_PARK:
      begin
        // One idle cycle so an interrupted strobe is seen to drop before the home seek
        nxt_q.target = CYL_HOME;
        nxt_q.strb_cnt = '0;
        nxt_q.st = ST_STRB;
      end
    endcase

    // Stop, or leaving the random position, parks the heads once
    if (running && !q_ff.stopping && (q_ff.panel.stop || q_ff.panel.func != FUNC_RANDOM))
    begin
      nxt_q.stopping = 1'b1;
      nxt_q.st = ST_PARK;
    end

    // Avalon slave: waitrequest low for one cycle after a request is seen
    nxt_q.wait_rq = !(bus_req && q_ff.wait_rq);
    if (bus_req && q_ff.wait_rq)
    begin
      nxt_q.rdata = '0;
      if (avs_read)
      begin
        unique case (avs_address)
          REG_DELAY: nxt_q.rdata[9:0] = q_ff.delay_reg;
          REG_STATUS:
          begin
            nxt_q.rdata[ST_TARGET_LSB +: 9] = q_ff.target;
            nxt_q.rdata[ST_STATE_LSB +: 3] = q_ff.st;
            nxt_q.rdata[ST_RUN_BIT] = running;
            nxt_q.rdata[ST_STOP_BIT] = q_ff.stopping;
          end
          default: nxt_q.rdata = '0;
        endcase
      end
    end
    if (avs_write && !q_ff.wait_rq && avs_address == REG_DELAY)
    begin
      if (avs_byteenable[0])
        wr_delay[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1])
        wr_delay[9:8] = avs_writedata[9:8];
      // Readout has three digits, so larger settings are held at 999
      nxt_q.delay_reg = (wr_delay > DELAY_MAX) ? DELAY_MAX : wr_delay;
    end

    nxt_q.readout = to_bcd(nxt_q.delay_reg);
    nxt_q.tag_led = nxt_q.panel.tag;

    // Bus outputs follow the next state so they align with it
    nxt_q.drive = '{tag: TAG_IDLE, ctl: 16'h0000, strobe: 1'b0};
    if (nxt_q.st == ST_STRB)
    begin
      nxt_q.drive.tag = TAG_SEEK;
      nxt_q.drive.ctl = {7'h00, nxt_q.target};
      nxt_q.drive.strobe = 1'b1;
    end
    else if (nxt_q.st == ST_IDLE && nxt_q.panel.func == FUNC_MANUAL)
    begin
      // Write code is swapped for an idle tag with no strobe
      if (nxt_q.panel.tag != TAG_WRITE)
      begin
        nxt_q.drive.tag = nxt_q.panel.tag;
        nxt_q.drive.strobe = nxt_q.panel.start;
      end
      nxt_q.drive.ctl = nxt_q.panel.ctl;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      q_ff <= RESET_Q;
    else
      q_ff <= nxt_q;
  end

  assign avs_readdata = q_ff.rdata;
  assign avs_waitrequest = q_ff.wait_rq;
  assign drive = q_ff.drive;
  assign tag_led = q_ff.tag_led;
  assign delay_readout = q_ff.readout;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence rand_start_s;
    q_ff.st == ST_IDLE && q_ff.panel.func == FUNC_RANDOM && start_edge;
  endsequence

  sequence home_seek_s;
    drive.strobe && drive.tag == TAG_SEEK && drive.ctl == 16'h0000;
  endsequence

  sequence stop_req_s;
    running && !q_ff.stopping && q_ff.panel.stop;
  endsequence

  random_start_a: assert property (rand_start_s |=> home_seek_s)
    else $error("random start did not seek home");

  stop_home_a: assert property (stop_req_s |=> !drive.strobe ##1 home_seek_s)
    else $error("stop did not seek home");

  stop_final_a: assert property ($fell(q_ff.stopping && drive.strobe)
    |-> q_ff.st == ST_IDLE ##1 (q_ff.st != ST_STRB)[*8])
    else $error("seek issued after stop");

  wait_load_a: assert property ($rose(q_ff.st == ST_WAIT) |-> q_ff.delay_cnt == $past(q_ff.delay_reg))
    else $error("wait not loaded from delay");

  wait_tick_a: assert property (q_ff.st == ST_WAIT && q_ff.delay_cnt != 0 && !tick |=> $stable(q_ff.delay_cnt))
    else $error("delay counted without tick");

  manual_strobe_a: assert property (q_ff.st == ST_IDLE && q_ff.panel.func == FUNC_MANUAL && q_ff.panel.tag != TAG_WRITE
    |-> drive.strobe == q_ff.panel.start && drive.tag == q_ff.panel.tag)
    else $error("manual strobe mismatch");

  manual_ctl_a: assert property (drive.strobe && q_ff.st == ST_IDLE |-> drive.ctl == q_ff.panel.ctl)
    else $error("manual control word mismatch");

  no_write_a: assert property (drive.tag != TAG_WRITE)
    else $error("write tag on bus");

  write_block_a: assert property (q_ff.st == ST_IDLE && q_ff.panel.func == FUNC_MANUAL
    && q_ff.panel.tag == TAG_WRITE |-> !drive.strobe && drive.tag == TAG_IDLE)
    else $error("write tag not blocked");

  tag_led_a: assert property (tag_led == q_ff.panel.tag)
    else $error("tag indicators stale");

  seek_word_a: assert property (q_ff.st == ST_STRB |-> drive.tag == TAG_SEEK && drive.ctl[15:9] == 7'h00)
    else $error("bad seek word");

  cyl_limit_a: assert property (q_ff.st == ST_STRB |-> drive.ctl[8:0] <= CYL_MAX)
    else $error("cylinder above limit");

  lfsr_skip_a: assert property (q_ff.st == ST_PICK && q_ff.lfsr > CYL_MAX |=> q_ff.st != ST_STRB)
    else $error("out of range value used");

  bus_ack_a: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest handshake broken");
endmodule

// ---- sim/svt_drive_model.sv ----
`timescale 1ns/1ps
// Drive end: latches tag and control on each strobe rise
module svt_drive_model
  import svt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Tag and control buses
  input wire svt_drive_t drive,
  // Capture record
  output int seek_n,
  output logic [3:0] last_tag,
  output logic [15:0] last_ctl,
  output logic bad_seen
);
  logic strobe_ff;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strobe_ff <= 1'b0;
      seek_n <= 0;
      last_tag <= 4'h0;
      last_ctl <= 16'h0000;
      bad_seen <= 1'b0;
    end
    else
    begin
      strobe_ff <= drive.strobe;
      if (drive.strobe && !strobe_ff)
      begin
        seek_n <= seek_n + 1;
        last_tag <= drive.tag;
        last_ctl <= drive.ctl;
        if (drive.tag == TAG_WRITE || (drive.tag == TAG_SEEK && drive.ctl[8:0] > CYL_MAX))
          bad_seen <= 1'b1;
      end
    end
  end
endmodule

// ---- sim/svt_seek_manual_tb_top.sv ----
`timescale 1ns/1ps
module svt_seek_manual_tb_top
  import svt_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  svt_panel_t panel = '0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  svt_drive_t drive;
  logic [3:0] tag_led;
  logic [11:0] delay_readout;
  int seek_n, n0, bad_count = 0, n_compared = 0;
  logic [3:0] last_tag;
  logic [15:0] last_ctl;
  logic bad_seen;

  always #4 clock = ~clock;

  svt_seek_manual #(.TICK_CYC(10)) u_svt_seek_manual (.clock(clock), .reset_n(reset_n), .panel_pins(panel),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .drive(drive), .tag_led(tag_led), .delay_readout(delay_readout));
  svt_drive_model u_svt_drive_model (.clock(clock), .reset_n(reset_n), .drive(drive), .seek_n(seek_n),
    .last_tag(last_tag), .last_ctl(last_ctl), .bad_seen(bad_seen));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // Request holds until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clock);
    end
    while (avs_waitrequest !== 1'b0);
    if (!wr)
      chk("readdata", exp, avs_readdata);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    give_verdict();
  end

  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    cyc(2);
    chk("readout", 32'h100, delay_readout);
    bus(1'b0, REG_DELAY, 32'h0, 32'h64);
    bus(1'b1, REG_DELAY, 32'h3FF, 32'h0);
    bus(1'b0, REG_DELAY, 32'h0, 32'h3E7);
    avs_byteenable <= 4'h2;
    bus(1'b1, REG_DELAY, 32'h100, 32'h0);
    avs_byteenable <= 4'h3;
    bus(1'b0, REG_DELAY, 32'h0, 32'h1E7);
    bus(1'b0, 4'hC, 32'h0, 32'h0);
    bus(1'b1, REG_DELAY, 32'h1, 32'h0);
    cyc(3);
    chk("readout", 32'h001, delay_readout);
    $display("test registers done");
    panel.func <= FUNC_MANUAL;
    panel.tag <= 4'hD;
    panel.ctl <= 16'hA5C3;
    panel.start <= 1'b1;
    cyc(8);
    chk("strobe", 1, drive.strobe);
    chk("tag", 32'hD, drive.tag);
    chk("ctl", 32'hA5C3, drive.ctl);
    chk("tag_led", 32'hD, tag_led);
    chk("drive_ctl", 32'hA5C3, last_ctl);
    panel.start <= 1'b0;
    cyc(8);
    chk("strobe", 0, drive.strobe);
    panel.tag <= TAG_WRITE;
    panel.start <= 1'b1;
    cyc(8);
    chk("strobe", 0, drive.strobe);
    chk("tag", 32'h0, drive.tag);
    chk("tag_led", 32'h1, tag_led);
    panel.tag <= 4'hD;
    panel.func <= 4'h5;
    cyc(8);
    chk("other_strobe", 0, drive.strobe);
    chk("other_tag", 32'h0, drive.tag);
    panel.start <= 1'b0;
    $display("test manual done");
    panel.func <= FUNC_RANDOM;
    cyc(8);
    panel.start <= 1'b1;
    cyc(10);
    chk("strobe", 1, drive.strobe);
    chk("tag", 32'h8, drive.tag);
    chk("ctl", 32'h0, drive.ctl);
    panel.start <= 1'b0;
    n0 = seek_n;
    for (int i = 0; i < 4000 && seek_n < n0 + 5; i++)
      cyc(1);
    chk("seeks", n0 + 5, seek_n);
    chk("seek_tag", 32'h8, last_tag);
    chk("in_range", 0, bad_seen);
    panel.stop <= 1'b1;
    cyc(400);
    chk("home", 32'h0, last_ctl);
    chk("strobe", 0, drive.strobe);
    n0 = seek_n;
    cyc(300);
    chk("no_more", n0, seek_n);
    bus(1'b0, REG_STATUS, 32'h0, 32'h2000);
    panel.stop <= 1'b0;
    $display("test random done");
    n0 = seek_n;
    cyc(8);
    panel.start <= 1'b1;
    for (int i = 0; i < 4000 && seek_n < n0 + 2; i++)
      cyc(1);
    chk("seeks2", n0 + 2, seek_n);
    panel.start <= 1'b0;
    panel.func <= FUNC_MANUAL;
    cyc(400);
    chk("home2", 32'h0, last_ctl);
    chk("idle_strobe", 0, drive.strobe);
    $display("test park done");
    give_verdict();
  end
endmodule
